// ==== logic/slt_line_ctrl.sv ====
/*
 * slt_line_ctrl: line settings, transmit keying (RTS/CTS), DTR/DCD handling,
 * protocol timer values and the host command request watchdog of one port.
 * assumes: a plain register port on clk; cts and dcd arrive unsynchronised.
 */
// The address map and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/100ps
//Contract
//- line rate selectable among seven bauds 300..19200; 19200 after reset.
//- per-port RS-485 or RS-232 selection decides how the line is driven.
//- on the smaller variant port 1 is always RS-232.
//- flow control is NONE or HARDWARE and picks the modem-line behaviour.
//- no hardware handshake when the port runs RS-485.
//- NONE: RTS high through turnaround and sending, dropped when last char ends.
//- NONE: RTS held for the turnaround delay before the first character.
//- turnaround delay none, 10, 100 or 500 ms; none after reset.
//- HARDWARE: RTS raised at start; characters wait for CTS from remote.
//- HARDWARE: RTS dropped right after the last character is sent.
//- HARDWARE: turnaround delay does not time RTS; it extends protocol timers.
//- incoming DCD is the remote asking the receiver to get ready.
//- DTR is driven high from start-up and never dropped.
//- timer_one..timer_five loaded per timeout choice as tabled.
//- timer_three is base minus 80 chars; extended adds 65 s.
//- timer_five_ext adds 80 chars; timer_five_long adds delay and two messages.
//- transmission delay is 0 s for every timeout choice, settable.
//- host command request aborted after 30 s with a timeout status code.
module slt_line_ctrl
   import slt_pkg::*;
#(
   parameter int CLK_HZ         = slt_pkg::CLK_HZ_DEF,
   parameter bit SMALL_VARIANT  = 1'b0,
   parameter int PORT_NUM       = 1,
   parameter int TX_DELAY_US    = slt_pkg::TX_DELAY_S * slt_pkg::US_PER_S,
   parameter int CMD_TIMEOUT_US = slt_pkg::CMD_TIMEOUT_S * slt_pkg::US_PER_S
) (
   // clock and reset
   input  wire logic                      clk,
   input  wire logic                      rst_n,
   // register port
   input  wire logic [slt_pkg::ADDR_W-1:0] addr,
   input  wire logic [slt_pkg::DATA_W-1:0] wdata,
   input  wire logic                      wr,
   input  wire logic                      rd,
   output      logic [slt_pkg::DATA_W-1:0] rdata,
   // serial line
   output      logic                      td,
   output      logic                      td_oe,
   output      logic                      rts,
   input  wire logic                      cts,
   input  wire logic                      dcd,
   output      logic                      dtr,
   output      logic                      rx_en
);
   import slt_pkg::*;

   localparam int US_CYC = CLK_HZ / US_PER_S;

   typedef enum logic [1:0] {
      SLT_TX_IDLE = 2'b00,
      SLT_TX_KEY  = 2'b01,
      SLT_TX_SEND = 2'b11
   } slt_tx_e;

   typedef struct packed {
      slt_cfg_s                cfg;
      logic [11:0]             msg_len;
      logic [2:0]              tsel;
      slt_tx_e                 st;
      logic [1:0]              cts_q;
      logic [1:0]              dcd_q;
      logic [31:0]             wait_us;
      logic                    close_req;
      logic                    hold_full;
      logic [7:0]              hold;
      logic [11:0]             frame;
      logic [3:0]              bits_left;
      logic [31:0]             baud_cnt;
      logic [6:0]              us_cnt;
      logic                    tick;
      logic [TMR_N-1:0]        tstart;
      logic [TMR_N-1:0]        tstop;
      logic                    cmd_busy;
      logic [31:0]             cmd_us;
      logic [15:0]             cmd_word;
      logic [DATA_W-1:0]       rdata;
      logic                    rts;
      logic                    dtr;
      logic                    td;
      logic                    td_oe;
      logic                    rx_en;
   } slt_state_s;

   slt_state_s q;
   slt_state_s next_q;

   slt_tmr_if #(.N(TMR_N)) tmr ();

   slt_timer_bank #(.N(TMR_N)) u_bank (
      .clk   (clk),
      .rst_n (rst_n),
      .tmr   (tmr.bank)
   );

   // bit time in microseconds, rounded up
   function automatic logic [31:0] bit_us(input slt_baud_e b);
      case (b)
         SLT_B300:   bit_us = 32'(US_PER_S / 300 + 1);
         SLT_B600:   bit_us = 32'(US_PER_S / 600 + 1);
         SLT_B1200:  bit_us = 32'(US_PER_S / 1200 + 1);
         SLT_B2400:  bit_us = 32'(US_PER_S / 2400 + 1);
         SLT_B4800:  bit_us = 32'(US_PER_S / 4800 + 1);
         SLT_B9600:  bit_us = 32'(US_PER_S / 9600 + 1);
         default:    bit_us = 32'(US_PER_S / 19200 + 1);
      endcase
   endfunction

   // clock cycles per bit
   function automatic logic [31:0] bit_cyc(input slt_baud_e b);
      case (b)
         SLT_B300:   bit_cyc = 32'(CLK_HZ / 300);
         SLT_B600:   bit_cyc = 32'(CLK_HZ / 600);
         SLT_B1200:  bit_cyc = 32'(CLK_HZ / 1200);
         SLT_B2400:  bit_cyc = 32'(CLK_HZ / 2400);
         SLT_B4800:  bit_cyc = 32'(CLK_HZ / 4800);
         SLT_B9600:  bit_cyc = 32'(CLK_HZ / 9600);
         default:    bit_cyc = 32'(CLK_HZ / 19200);
      endcase
   endfunction

   function automatic logic [31:0] ms_to_us(input int ms);
      ms_to_us = 32'(ms * US_PER_MS);
   endfunction

   function automatic logic [31:0] s_to_us(input int s);
      s_to_us = 32'(s * US_PER_S);
   endfunction

   // effective line settings
   logic        eff_485;
   logic        eff_hw;
   logic [3:0]  char_bits;
   logic [31:0] char_us;
   logic [31:0] ext_us;
   logic [31:0] tad_us;
   logic [31:0] extra_us;
   logic [31:0] t2_us;
   logic [31:0] t3b_us;
   logic [31:0] t5_us;
   logic        cts_ok;
   logic        send_done;
   logic        par_bit;

   always_comb begin
      eff_485   = q.cfg.iface485 && !(SMALL_VARIANT && PORT_NUM == 1);
      eff_hw    = q.cfg.flow_hw && !eff_485;
      char_bits = 4'(1 + DATA_BITS) + ((q.cfg.parity != SLT_PAR_NONE) ? 4'h1 : 4'h0)
                  + (q.cfg.stop2 ? 4'h2 : 4'h1);
      char_us   = 32'(char_bits) * bit_us(q.cfg.baud);
      ext_us    = 32'(EXT_CHARS) * char_us;
      case (q.cfg.tad)
         SLT_TAD_10:  tad_us = ms_to_us(TAD_10_MS);
         SLT_TAD_100: tad_us = ms_to_us(TAD_100_MS);
         SLT_TAD_500: tad_us = ms_to_us(TAD_500_MS);
         default:     tad_us = 32'h0;
      endcase
      extra_us = eff_hw ? tad_us : 32'h0;
      case (q.cfg.tmo)
         SLT_TMO_SHORT: begin
            t2_us  = ms_to_us(T2_SHORT_MS);
            t3b_us = s_to_us(T3B_SHORT_S);
            t5_us  = s_to_us(T5_SHORT_S);
         end
         SLT_TMO_MEDIUM: begin
            t2_us  = s_to_us(T2_MEDIUM_S);
            t3b_us = s_to_us(T3B_LONG_S);
            t5_us  = s_to_us(T5_MEDIUM_S);
         end
         SLT_TMO_LONG: begin
            t2_us  = s_to_us(T2_LONG_S);
            t3b_us = s_to_us(T3B_LONG_S);
            t5_us  = TMR_DISABLED;
         end
         default: begin
            t2_us  = s_to_us(T2_LONG_S);
            t3b_us = TMR_DISABLED;
            t5_us  = TMR_DISABLED;
         end
      endcase
      par_bit = (q.cfg.parity == SLT_PAR_ODD) ? ~^q.hold : ^q.hold;
   end

   // protocol timer load values
   always_comb begin
      tmr.load[TMR_ONE]  = ms_to_us(T1_MS) + extra_us;
      tmr.load[TMR_TWO]  = t2_us + extra_us;
      tmr.load[TMR_FOUR] = ms_to_us(T4_MS) + extra_us;
      tmr.load[TMR_THREE]     = t3b_us - ext_us + extra_us;
      tmr.load[TMR_THREE_EXT] = t3b_us - ext_us + s_to_us(T3_EXTRA_S) + extra_us;
      tmr.load[TMR_FIVE]      = t5_us + extra_us;
      tmr.load[TMR_FIVE_EXT]  = t5_us + ext_us + extra_us;
      tmr.load[TMR_FIVE_LONG] = t5_us + 32'(TX_DELAY_US) + 32'h2 * (32'(q.msg_len) * char_us)
                                + extra_us;
      tmr.disabled = '0;
      tmr.disabled[TMR_THREE]     = (t3b_us == TMR_DISABLED);
      tmr.disabled[TMR_THREE_EXT] = (t3b_us == TMR_DISABLED);
      tmr.disabled[TMR_FIVE]      = (t5_us == TMR_DISABLED);
      tmr.disabled[TMR_FIVE_EXT]  = (t5_us == TMR_DISABLED);
      tmr.disabled[TMR_FIVE_LONG] = (t5_us == TMR_DISABLED);
   end

   assign tmr.tick  = q.tick;
   assign tmr.start = q.tstart;
   assign tmr.stop  = q.tstop;

   always_comb begin
      next_q        = q;
      next_q.cts_q  = {q.cts_q[0], cts};
      next_q.dcd_q  = {q.dcd_q[0], dcd};
      next_q.tstart = '0;
      next_q.tstop  = '0;
      next_q.rdata  = '0;
      next_q.dtr    = 1'b1;
      next_q.rx_en  = q.dcd_q[1];
      cts_ok        = !eff_hw || q.cts_q[1];
      send_done     = (q.bits_left == 4'h0);

      // microsecond tick
      next_q.tick = 1'b0;
      if (q.us_cnt >= 7'(US_CYC - 1)) begin
         next_q.us_cnt = 7'h0;
         next_q.tick   = 1'b1;
      end else begin
         next_q.us_cnt = q.us_cnt + 7'h1;
      end

      // register writes
      if (wr) begin
         case (addr)
            OFF_CFG:     next_q.cfg = slt_cfg_s'({20'h0, wdata[11:0]});
            OFF_TX_CTL:  if (wdata[TX_CLOSE_BIT]) next_q.close_req = 1'b1;
            OFF_TX_DATA: if (!q.hold_full) begin
               next_q.hold      = wdata[7:0];
               next_q.hold_full = 1'b1;
            end
            OFF_TMR_CTL: begin
               next_q.tstart = wdata[TMR_N-1:0];
               next_q.tstop  = wdata[TMR_STOP_LSB +: TMR_N];
            end
            OFF_MSG_LEN: next_q.msg_len = wdata[11:0];
            OFF_TMR_SEL: next_q.tsel = wdata[2:0];
            OFF_CMD_CTL: begin
               if (wdata[CMD_BEGIN_BIT]) begin
                  next_q.cmd_busy = 1'b1;
                  next_q.cmd_us   = 32'h0;
                  next_q.cmd_word = CMD_ST_BUSY;
               end else if (wdata[CMD_FINISH_BIT] && q.cmd_busy) begin
                  next_q.cmd_busy = 1'b0;
                  next_q.cmd_word = CMD_ST_OK;
               end
            end
            default: ;
         endcase
      end

      // command request watchdog; expiry wins over a finish in the same cycle
      if (q.cmd_busy && q.tick) begin
         if (q.cmd_us >= 32'(CMD_TIMEOUT_US - 1)) begin
            next_q.cmd_busy = 1'b0;
            next_q.cmd_word = CMD_ST_TIMEOUT;
         end else begin
            next_q.cmd_us = q.cmd_us + 32'h1;
         end
      end

      // transmit sequencing
      case (q.st)
         SLT_TX_IDLE: begin
            next_q.close_req = 1'b0;
            if (wr && addr == OFF_TX_CTL && wdata[TX_OPEN_BIT]) begin
               next_q.st      = SLT_TX_KEY;
               next_q.rts     = 1'b1;
               next_q.wait_us = eff_hw ? 32'h0 : tad_us;
            end
         end
         SLT_TX_KEY: begin
            if (q.wait_us != 32'h0) begin
               if (q.tick) next_q.wait_us = q.wait_us - 32'h1;
            end else if (cts_ok) begin
               next_q.st = SLT_TX_SEND;
            end
         end
         SLT_TX_SEND: begin
            if (!send_done) begin
               if (q.baud_cnt >= bit_cyc(q.cfg.baud) - 32'h1) begin
                  next_q.baud_cnt  = 32'h0;
                  next_q.bits_left = q.bits_left - 4'h1;
                  next_q.frame     = {1'b1, q.frame[11:1]};
                  next_q.td        = q.frame[1];
                  if (q.bits_left == 4'h1) next_q.td = 1'b1;
               end else begin
                  next_q.baud_cnt = q.baud_cnt + 32'h1;
               end
            end else if (q.hold_full && cts_ok) begin
               next_q.hold_full = 1'b0;
               next_q.baud_cnt  = 32'h0;
               next_q.bits_left = char_bits;
               next_q.frame     = (q.cfg.parity == SLT_PAR_NONE) ? {3'b111, q.hold, 1'b0}
                                                                : {2'b11, par_bit, q.hold, 1'b0};
               next_q.td        = 1'b0;
            end else if (q.close_req && !q.hold_full) begin
               next_q.st  = SLT_TX_IDLE;
               next_q.rts = 1'b0;
            end
         end
         default: begin
            next_q.st  = SLT_TX_IDLE;
            next_q.rts = 1'b0;
         end
      endcase
      if (q.st != SLT_TX_SEND && q.st != SLT_TX_IDLE && q.close_req && !q.hold_full) begin
         next_q.st  = SLT_TX_IDLE;
         next_q.rts = 1'b0;
      end

      next_q.td_oe = eff_485 ? next_q.rts : 1'b1;

      // register reads
      if (rd) begin
         case (addr)
            OFF_CFG:      next_q.rdata = DATA_W'(q.cfg);
            OFF_STATUS:   next_q.rdata = {24'h0, q.cmd_busy, eff_hw, eff_485, q.st != SLT_TX_IDLE,
                                          q.hold_full, q.dcd_q[1], q.cts_q[1], q.rts};
            OFF_TMR_STAT: next_q.rdata = {16'h0, tmr.running, tmr.expired};
            OFF_MSG_LEN:  next_q.rdata = {20'h0, q.msg_len};
            OFF_TMR_SEL:  next_q.rdata = {29'h0, q.tsel};
            OFF_TMR_VAL:  next_q.rdata = tmr.disabled[q.tsel] ? TMR_DISABLED : tmr.load[q.tsel];
            OFF_CHAR_US:  next_q.rdata = char_us;
            OFF_CMD_STAT: next_q.rdata = {16'h0, q.cmd_word};
            default:      next_q.rdata = '0;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         q           <= '0;
         q.cfg       <= CFG_RST;
         q.st        <= SLT_TX_IDLE;
         q.td        <= 1'b1;
         q.td_oe     <= 1'b1;
         q.dtr       <= 1'b1;
         q.cmd_word  <= CMD_ST_IDLE;
      end else begin
         q <= next_q;
      end
   end

   assign rdata = q.rdata;
   assign td    = q.td;
   assign td_oe = q.td_oe;
   assign rts   = q.rts;
   assign dtr   = q.dtr;
   assign rx_en = q.rx_en;
endmodule

// ==== logic/slt_pkg.sv ====
/*
 * slt_pkg: register map, configuration layout, codes and timing figures for the
 * serial line-control and protocol-timer block.
 * assumes: a single 100 MHz clock and a plain address/strobe register port.
 */
package slt_pkg;
   // clock and time units
   localparam int          CLK_HZ_DEF     = 100_000_000;
   localparam int          US_PER_S       = 1_000_000;
   localparam int          US_PER_MS      = 1_000;

   // register port
   localparam int          ADDR_W         = 4;
   localparam int          DATA_W         = 32;
   localparam logic [3:0]  OFF_CFG        = 4'h0;
   localparam logic [3:0]  OFF_TX_CTL     = 4'h1;
   localparam logic [3:0]  OFF_TX_DATA    = 4'h2;
   localparam logic [3:0]  OFF_STATUS     = 4'h3;
   localparam logic [3:0]  OFF_TMR_CTL    = 4'h4;
   localparam logic [3:0]  OFF_TMR_STAT   = 4'h5;
   localparam logic [3:0]  OFF_MSG_LEN    = 4'h6;
   localparam logic [3:0]  OFF_TMR_SEL    = 4'h7;
   localparam logic [3:0]  OFF_TMR_VAL    = 4'h8;
   localparam logic [3:0]  OFF_CHAR_US    = 4'h9;
   localparam logic [3:0]  OFF_CMD_CTL    = 4'ha;
   localparam logic [3:0]  OFF_CMD_STAT   = 4'hb;

   // field positions of the write-only control words
   localparam int          TX_OPEN_BIT    = 0;
   localparam int          TX_CLOSE_BIT   = 1;
   localparam int          CMD_BEGIN_BIT  = 0;
   localparam int          CMD_FINISH_BIT = 1;
   localparam int          TMR_STOP_LSB   = 8;

   // configuration enumerations
   typedef enum logic [2:0] {
      SLT_B300 = 3'h0, SLT_B600 = 3'h1, SLT_B1200 = 3'h2, SLT_B2400 = 3'h3,
      SLT_B4800 = 3'h4, SLT_B9600 = 3'h5, SLT_B19200 = 3'h6
   } slt_baud_e;
   typedef enum logic [1:0] {SLT_PAR_NONE = 2'h0, SLT_PAR_ODD = 2'h1, SLT_PAR_EVEN = 2'h2} slt_par_e;
   typedef enum logic [1:0] {SLT_TMO_NONE = 2'h0, SLT_TMO_SHORT = 2'h1, SLT_TMO_MEDIUM = 2'h2,
                             SLT_TMO_LONG = 2'h3} slt_tmo_e;
   typedef enum logic [1:0] {SLT_TAD_NONE = 2'h0, SLT_TAD_10 = 2'h1, SLT_TAD_100 = 2'h2,
                             SLT_TAD_500 = 2'h3} slt_tad_e;

   // configuration word, msb first
   typedef struct packed {
      logic [19:0] rsvd;
      slt_tad_e    tad;
      slt_tmo_e    tmo;
      logic        flow_hw;
      logic        iface485;
      logic        stop2;
      slt_par_e    parity;
      slt_baud_e   baud;
   } slt_cfg_s;
   localparam slt_cfg_s CFG_RST = '{rsvd: 20'h0, tad: SLT_TAD_NONE, tmo: SLT_TMO_LONG, flow_hw: 1'b0,
                                   iface485: 1'b0, stop2: 1'b0, parity: SLT_PAR_ODD, baud: SLT_B19200};

   // character framing
   localparam int          DATA_BITS      = 8;

   // protocol timers
   localparam int          TMR_N          = 8;
   localparam int          TMR_ONE        = 0;
   localparam int          TMR_TWO        = 1;
   localparam int          TMR_THREE      = 2;
   localparam int          TMR_THREE_EXT  = 3;
   localparam int          TMR_FOUR       = 4;
   localparam int          TMR_FIVE       = 5;
   localparam int          TMR_FIVE_EXT   = 6;
   localparam int          TMR_FIVE_LONG  = 7;
   localparam int          T1_MS          = 5;
   localparam int          T4_MS          = 50;
   localparam int          T2_SHORT_MS    = 500;
   localparam int          T2_MEDIUM_S    = 1;
   localparam int          T2_LONG_S      = 2;
   localparam int          T3B_SHORT_S    = 5;
   localparam int          T3B_LONG_S     = 10;
   localparam int          T5_SHORT_S     = 2;
   localparam int          T5_MEDIUM_S    = 5;
   localparam int          EXT_CHARS      = 80;
   localparam int          T3_EXTRA_S     = 65;
   localparam int          TX_DELAY_S     = 0;
   localparam int          TAD_10_MS      = 10;
   localparam int          TAD_100_MS     = 100;
   localparam int          TAD_500_MS     = 500;
   localparam logic [31:0] TMR_DISABLED   = 32'hffff_ffff;

   // host command request
   localparam int          CMD_TIMEOUT_S  = 30;
   localparam logic [15:0] CMD_ST_IDLE    = 16'h0000;
   localparam logic [15:0] CMD_ST_BUSY    = 16'h0001;
   localparam logic [15:0] CMD_ST_OK      = 16'h0002;
   localparam logic [15:0] CMD_ST_TIMEOUT = 16'h00e1;
endpackage

// ==== logic/slt_timer_bank.sv ====
/*
 * slt_timer_bank: N microsecond countdown timers with sticky expiry flags.
 * assumes: start and stop are one-cycle strobes from the same clock.
 */
`timescale 1ns/100ps
module slt_timer_bank #(
   parameter int N = 8
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // timer control
   slt_tmr_if.bank  tmr
);
   typedef struct packed {
      logic [N-1:0][31:0] cnt;
      logic [N-1:0]       running;
      logic [N-1:0]       expired;
   } slt_bank_s;

   slt_bank_s q;
   slt_bank_s next_q;

   always_comb begin
      next_q = q;
      for (int i = 0; i < N; i++) begin
         if (tmr.start[i]) begin
            next_q.cnt[i]     = tmr.load[i];
            next_q.running[i] = 1'b1;
            next_q.expired[i] = 1'b0;
         end else if (tmr.stop[i]) begin
            next_q.running[i] = 1'b0;
         end else if (q.running[i] && tmr.tick && !tmr.disabled[i]) begin
            if (q.cnt[i] <= 32'h1) begin
               next_q.cnt[i]     = 32'h0;
               next_q.running[i] = 1'b0;
               next_q.expired[i] = 1'b1;
            end else begin
               next_q.cnt[i] = q.cnt[i] - 32'h1;
            end
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         q <= '0;
      end else begin
         q <= next_q;
      end
   end

   assign tmr.expired = q.expired;
   assign tmr.running = q.running;
endmodule

// ==== logic/slt_tmr_if.sv ====
/*
 * slt_tmr_if: start/stop strobes, load values and expiry status between the
 * line controller and its protocol timer bank.
 * assumes: one clock; tick is a one-cycle pulse once per microsecond.
 */
`timescale 1ns/100ps
interface slt_tmr_if #(parameter int N = 8);
   logic                tick;
   logic [N-1:0]        start;
   logic [N-1:0]        stop;
   logic [N-1:0][31:0]  load;
   logic [N-1:0]        disabled;
   logic [N-1:0]        expired;
   logic [N-1:0]        running;

   modport bank (input tick, start, stop, load, disabled, output expired, running);
   modport ctrl (output tick, start, stop, load, disabled, input expired, running);
endinterface

// ==== sim/slt_line_ctrl_properties.sv ====
/* slt_lc_chk: port-level checks of the line controller.
   assumes: bound to slt_line_ctrl; one clock; rst_n synchronous, active low. */
`timescale 1ns/100ps
module slt_lc_chk (
   // clock and reset
   input wire logic                       clk,
   input wire logic                       rst_n,
   // register port
   input wire logic [slt_pkg::ADDR_W-1:0] addr,
   input wire logic [slt_pkg::DATA_W-1:0] wdata,
   input wire logic                       wr,
   input wire logic                       rd,
   input wire logic [slt_pkg::DATA_W-1:0] rdata,
   // serial line
   input wire logic                       td,
   input wire logic                       td_oe,
   input wire logic                       rts,
   input wire logic                       cts,
   input wire logic                       dcd,
   input wire logic                       dtr,
   input wire logic                       rx_en
);
   import slt_pkg::*;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   wire open_req = wr && addr == OFF_TX_CTL && wdata[TX_OPEN_BIT];
   dtr_held_a: assert property (dtr)
      else $error("dtr dropped");
   rdata_quiet_a: assert property (!$past(rd) |-> rdata == '0)
      else $error("read data without a read");
   unmapped_zero_a: assert property (rd && addr > OFF_CMD_STAT |=> rdata == '0)
      else $error("unmapped read not zero");
   dcd_rise_a: assert property ($rose(dcd) |-> ##[1:3] rx_en)
      else $error("receiver not readied");
   dcd_fall_a: assert property ($fell(dcd) |-> ##[1:3] !rx_en)
      else $error("receiver still ready");
   td_idle_a: assert property (!rts |-> td)
      else $error("data sent without rts");
   oe_follow_a: assert property (!td_oe |-> !rts)
      else $error("driver off while keyed");
   rts_open_a: assert property ($rose(rts) |-> $past(open_req) || $past(open_req, 2))
      else $error("rts raised without open");
   rts_drop_a: assert property ($fell(rts) |-> $past(td) && $past(td, 8))
      else $error("rts dropped inside a frame");
endmodule

bind slt_line_ctrl slt_lc_chk i_slt_lc_chk (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
   .wr(wr), .rd(rd), .rdata(rdata), .td(td), .td_oe(td_oe), .rts(rts), .cts(cts), .dcd(dcd),
   .dtr(dtr), .rx_en(rx_en));

// ==== sim/slt_line_ctrl_tb.sv ====
/* slt_line_ctrl_tb: random and corner checks of settings, timers, keying and command watchdog.
   assumes: design built with CLK_HZ of 1 MHz (one cycle per us) and a 50 us command timeout. */
`timescale 1ns/100ps
module slt_line_ctrl_tb;
   import slt_pkg::*;
   localparam int CMD_US = 50;
   localparam int TAD_US[4] = '{0, 10_000, 100_000, 500_000};
   logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, dcd_req = 1'b0;
   logic [ADDR_W-1:0] addr = '0;
   logic [DATA_W-1:0] wdata = '0, rdata;
   logic td, td_oe, rts, cts, dcd, dtr, rx_en;
   logic [15:0] lag = 16'hffff;
   int err_count = 0, check_count = 0, cyc = 0, msg;
   slt_cfg_s cfg;
   always #5 clk = ~clk;
   slt_line_ctrl #(.CLK_HZ(1_000_000), .CMD_TIMEOUT_US(CMD_US)) i_slt_line_ctrl (.clk(clk),
      .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .td(td),
      .td_oe(td_oe), .rts(rts), .cts(cts), .dcd(dcd), .dtr(dtr), .rx_en(rx_en));
   slt_remote i_slt_remote (.clk(clk), .rts(rts), .cts(cts), .dcd(dcd), .lag(lag), .dcd_req(dcd_req));
   task automatic close_out();
      $display("checks %0d errors %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 40_000) begin
         err_count++;
         close_out();
      end
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_count++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 check(rdata, exp);
   endtask
   function automatic int char_us(slt_cfg_s c);
      return (1_000_000 / (300 << c.baud) + 1) * (10 + int'(c.parity != SLT_PAR_NONE) + int'(c.stop2));
   endfunction
   function automatic logic [31:0] tmr_exp(slt_cfg_s c, int i);
      int ch, t3b, t5, v;
      ch = char_us(c);
      t3b = c.tmo == SLT_TMO_NONE ? -1 : (c.tmo == SLT_TMO_SHORT ? 5_000_000 : 10_000_000);
      t5 = c.tmo == SLT_TMO_SHORT ? 2_000_000 : (c.tmo == SLT_TMO_MEDIUM ? 5_000_000 : -1);
      case (i)
         0: v = 5_000;
         1: v = c.tmo == SLT_TMO_SHORT ? 500_000 : (c.tmo == SLT_TMO_MEDIUM ? 1_000_000 : 2_000_000);
         2: v = t3b - 80 * ch;
         3: v = t3b - 80 * ch + 65_000_000;
         4: v = 50_000;
         5: v = t5;
         6: v = t5 + 80 * ch;
         default: v = t5 + 2 * msg * ch;
      endcase
      if ((i inside {2, 3} && t3b < 0) || (i > 4 && t5 < 0))
         return TMR_DISABLED;
      return 32'(v + ((c.flow_hw && !c.iface485) ? TAD_US[c.tad] : 0));
   endfunction
   task automatic send(input logic [7:0] d, input int gap);
      int n;
      logic [7:0] got;
      wr_reg(OFF_TX_CTL, 32'h1);
      wr_reg(OFF_TX_DATA, {24'h0, d});
      wr_reg(OFF_TX_CTL, 32'h2);
      n = 4;
      while (td === 1'b1 && n < 30_000) begin
         @(posedge clk) #1;
         n++;
      end
      check(32'(n >= gap && n <= gap + 16), 32'h1);
      repeat (26) @(posedge clk);
      for (int b = 0; b < 9; b++) begin
         #1 got = {td, got[7:1]};
         repeat (53) @(posedge clk);
      end
      check(got, d);
      n = 0;
      while (rts === 1'b1 && n < 400) begin
         @(posedge clk) #1;
         n++;
      end
      repeat (2) @(posedge clk);
      #1 check({rts, td_oe, dtr}, {1'b0, !cfg.iface485, 1'b1});
   endtask
   initial begin
      void'($urandom(32'h4203e419));
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      rd_chk(OFF_CFG, CFG_RST);
      rd_chk(4'hf, 32'h0);
      rd_chk(OFF_STATUS, 32'h0);
      for (int k = 0; k < 16; k++) begin
         cfg = CFG_RST;
         cfg.baud = slt_baud_e'(k % 7);
         cfg.parity = slt_par_e'($urandom_range(2));
         cfg.stop2 = 1'($urandom);
         cfg.tmo = slt_tmo_e'(k[1:0]);
         cfg.flow_hw = k[2];
         cfg.iface485 = k[3];
         cfg.tad = slt_tad_e'($urandom_range(3));
         msg = $urandom_range(4095);
         wr_reg(OFF_CFG, cfg);
         wr_reg(OFF_MSG_LEN, 32'(msg));
         rd_chk(OFF_CFG, cfg);
         rd_chk(OFF_CHAR_US, 32'(char_us(cfg)));
         rd_chk(OFF_STATUS, {25'h0, cfg.flow_hw && !cfg.iface485, cfg.iface485, 5'h0});
         for (int i = 0; i < TMR_N; i++) begin
            wr_reg(OFF_TMR_SEL, 32'(i));
            rd_chk(OFF_TMR_VAL, tmr_exp(cfg, i));
         end
      end
      cfg = CFG_RST;
      cfg.tad = SLT_TAD_10;
      wr_reg(OFF_CFG, cfg);
      send(8'($urandom), 10_000);
      cfg.flow_hw = 1'b1;
      cfg.tad = SLT_TAD_500;
      lag = 16'd300;
      wr_reg(OFF_CFG, cfg);
      send(8'h80, 301);
      cfg.iface485 = 1'b1;
      cfg.tad = SLT_TAD_NONE;
      lag = 16'hffff;
      wr_reg(OFF_CFG, cfg);
      send(8'($urandom), 0);
      dcd_req <= 1'b1;
      repeat (8) @(posedge clk);
      #1 check(rx_en, 1'b1);
      dcd_req <= 1'b0;
      repeat (8) @(posedge clk);
      #1 check(rx_en, 1'b0);
      wr_reg(OFF_CMD_CTL, 32'h1);
      repeat (CMD_US - 10) @(posedge clk);
      rd_chk(OFF_CMD_STAT, CMD_ST_BUSY);
      repeat (12) @(posedge clk);
      rd_chk(OFF_CMD_STAT, CMD_ST_TIMEOUT);
      wr_reg(OFF_CMD_CTL, 32'h1);
      wr_reg(OFF_CMD_CTL, 32'h2);
      rd_chk(OFF_CMD_STAT, CMD_ST_OK);
      close_out();
   end
endmodule

// ==== sim/slt_remote.sv ====
/* slt_remote: far-side modem; answers rts with cts after a lag and raises dcd on demand.
   assumes: bench sets lag and dcd_req after a clock edge; lag ffff never answers. */
`timescale 1ns/100ps
module slt_remote (
   // clock
   input  wire logic        clk,
   // modem lines
   input  wire logic        rts,
   output      logic        cts,
   output      logic        dcd,
   // scenario control
   input  wire logic [15:0] lag,
   input  wire logic        dcd_req
);
   logic [15:0] wait_cnt = 16'h0;
   initial cts = 1'b0;
   initial dcd = 1'b0;
   always @(posedge clk) begin
      wait_cnt <= rts ? wait_cnt + 16'h1 : 16'h0;
      cts <= rts && lag != 16'hffff && wait_cnt >= lag;
      dcd <= dcd_req;
   end
endmodule
